// *** inc/dfbs_cfg.svh ***
// Purpose: Constants for the dual flash die bus select block
// Assumes: Levels on the memory bus pins are synchronous to sys_clk_i
// Notes: Functional notes follow
`ifndef DFBS_CFG_SVH
`define DFBS_CFG_SVH
`define DFBS_DATA_W 16
`define DFBS_LOW_BYTE_W 8
`define DFBS_NUM_DIES 2
`define DFBS_WAIT_ASSERTED 1'b0
`define DFBS_DATA_RESET 16'h0000
`endif

// *** inc/dfbs_pkg.sv ***
// Purpose: Types for the dual flash die bus select block
// Assumes: Nothing beyond the constants header
// Notes: Operation codes per die
`default_nettype none
package dfbs_pkg;
    typedef enum logic [2:0] {
        DFBS_OP_RESET,
        DFBS_OP_STANDBY,
        DFBS_OP_OUT_DISABLE,
        DFBS_OP_SYNC_ARRAY_READ,
        DFBS_OP_ASYNC_READ,
        DFBS_OP_WRITE,
        DFBS_OP_WRITE_LOCKED
    } dfbs_op_t;
endpackage : dfbs_pkg
`default_nettype wire

// *** logic/dfbs_bus_select.sv ***
// Purpose: Per-die bus operation decode for two flash dies on one bus
// Assumes: Controller obeys the shared-bus protocol rules
// Notes: Data and wait outputs are registered
`timescale 1ns/100ps
`default_nettype none
`include "dfbs_cfg.svh"
module dfbs_bus_select (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Per-die controls
    input wire logic [`DFBS_NUM_DIES-1:0] chip_sel_n_i,
    input wire logic [`DFBS_NUM_DIES-1:0] out_en_n_i,
    // Shared controls
    input wire logic mem_reset_n_i,
    input wire logic write_en_n_i,
    input wire logic address_valid_strobe_n_i,
    input wire logic prog_volt_ok_i,
    // Per-die read state from the array side
    input wire logic [`DFBS_NUM_DIES-1:0] sync_mode_i,
    input wire logic [`DFBS_NUM_DIES-1:0] byte_read_i,
    input wire logic [`DFBS_NUM_DIES-1:0] wait_flow_i,
    input wire logic [`DFBS_DATA_W-1:0] die0_rdata_i,
    input wire logic [`DFBS_DATA_W-1:0] die1_rdata_i,
    // Data pin
    input wire logic [`DFBS_DATA_W-1:0] data_in_i,
    output logic [`DFBS_DATA_W-1:0] data_out_o,
    output logic data_oe_o,
    // Wait pin
    output logic wait_out_o,
    output logic wait_oe_o,
    // Decoded operation
    output logic [`DFBS_NUM_DIES-1:0] write_strobe_o,
    output logic [`DFBS_DATA_W-1:0] write_data_o,
    output dfbs_pkg::dfbs_op_t die0_op_o,
    output dfbs_pkg::dfbs_op_t die1_op_o
);

    // ****************************************
    // Decode function
    // ****************************************
    function automatic dfbs_pkg::dfbs_op_t dfbs_decode(input logic rst_n, input logic cs_n,
            input logic oe_n, input logic we_n, input logic adv_n, input logic sync, input logic vpp_ok);
        dfbs_pkg::dfbs_op_t op;
        op = dfbs_pkg::DFBS_OP_RESET;
        if (!rst_n) begin
            op = dfbs_pkg::DFBS_OP_RESET;
        end else if (cs_n) begin
            op = dfbs_pkg::DFBS_OP_STANDBY;
        end else if (!oe_n) begin
            // Read wins over a simultaneous write
            if (sync && !adv_n) begin
                op = dfbs_pkg::DFBS_OP_SYNC_ARRAY_READ;
            end else begin
                op = dfbs_pkg::DFBS_OP_ASYNC_READ;
            end
        end else if (!we_n) begin
            op = vpp_ok ? dfbs_pkg::DFBS_OP_WRITE : dfbs_pkg::DFBS_OP_WRITE_LOCKED;
        end else begin
            op = dfbs_pkg::DFBS_OP_OUT_DISABLE;
        end
        return op;
    endfunction : dfbs_decode

    // A die drives the data pins only while it reads
    function automatic logic dfbs_reads(input dfbs_pkg::dfbs_op_t op);
        logic rd;
        rd = 1'h0;
        case (op)
            dfbs_pkg::DFBS_OP_SYNC_ARRAY_READ: rd = 1'h1;
            dfbs_pkg::DFBS_OP_ASYNC_READ: rd = 1'h1;
            default: rd = 1'h0;
        endcase
        return rd;
    endfunction : dfbs_reads

    // A die holds the wait pin unless parked in standby or reset
    function automatic logic dfbs_owns_wait(input dfbs_pkg::dfbs_op_t op);
        logic own;
        own = 1'h1;
        case (op)
            dfbs_pkg::DFBS_OP_RESET: own = 1'h0;
            dfbs_pkg::DFBS_OP_STANDBY: own = 1'h0;
            default: own = 1'h1;
        endcase
        return own;
    endfunction : dfbs_owns_wait

    // Query and status reads carry only the low byte; the high byte reads zero
    function automatic logic [`DFBS_DATA_W-1:0] dfbs_read_word(input logic [`DFBS_DATA_W-1:0] word,
            input logic low_only);
        logic [`DFBS_DATA_W-1:0] res;
        res = word;
        if (low_only) begin
            res = {{(`DFBS_DATA_W-`DFBS_LOW_BYTE_W){1'h0}}, word[`DFBS_LOW_BYTE_W-1:0]};
        end
        return res;
    endfunction : dfbs_read_word

    // ****************************************
    // Combinational decode of both dies
    // ****************************************
    dfbs_pkg::dfbs_op_t op_d [`DFBS_NUM_DIES];
    logic [`DFBS_DATA_W-1:0] rdata [`DFBS_NUM_DIES];
    logic [`DFBS_DATA_W-1:0] data_d;
    logic data_oe_d;
    logic wait_d;
    logic wait_oe_d;
    logic [`DFBS_NUM_DIES-1:0] strobe_d;

    // Each die sees its own select, enable and sync mode, shared others
    always_comb begin
        rdata[0] = die0_rdata_i;
        rdata[1] = die1_rdata_i;
        for (int i = 0; i < `DFBS_NUM_DIES; i++) begin
            op_d[i] = dfbs_decode(mem_reset_n_i, chip_sel_n_i[i], out_en_n_i[i], write_en_n_i,
                address_valid_strobe_n_i, sync_mode_i[i], prog_volt_ok_i);
        end
    end

    // Data pins: the reading die puts its word out
    always_comb begin
        data_d = '0;
        data_oe_d = 1'h0;
        for (int i = 0; i < `DFBS_NUM_DIES; i++) begin
            if (dfbs_reads(op_d[i])) begin
                // Two dies reading at once is a controller fault; the second die wins
                data_oe_d = 1'h1;
                data_d = dfbs_read_word(rdata[i], byte_read_i[i]);
            end
        end
    end

    // Wait pin: flow control only in synchronous array reads, asserted level otherwise
    always_comb begin
        wait_d = `DFBS_WAIT_ASSERTED;
        wait_oe_d = 1'h0;
        for (int i = 0; i < `DFBS_NUM_DIES; i++) begin
            if (dfbs_owns_wait(op_d[i])) begin
                wait_oe_d = 1'h1;
            end
            if (op_d[i] == dfbs_pkg::DFBS_OP_SYNC_ARRAY_READ) begin
                wait_d = wait_flow_i[i];
            end
        end
    end

    // Write strobes: a locked write never reaches the die
    always_comb begin
        strobe_d = '0;
        for (int i = 0; i < `DFBS_NUM_DIES; i++) begin
            strobe_d[i] = (op_d[i] == dfbs_pkg::DFBS_OP_WRITE);
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    logic [`DFBS_DATA_W-1:0] data_q;
    logic data_oe_q;
    logic wait_q;
    logic wait_oe_q;
    logic [`DFBS_NUM_DIES-1:0] strobe_q;
    logic [`DFBS_DATA_W-1:0] wdata_q;
    dfbs_pkg::dfbs_op_t die0_op_q;
    dfbs_pkg::dfbs_op_t die1_op_q;

    // Data pin drive
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_q <= `DFBS_DATA_RESET;
            data_oe_q <= 1'h0;
        end else begin
            data_q <= data_d;
            data_oe_q <= data_oe_d;
        end
    end

    // Wait pin drive; released while both dies are parked
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= `DFBS_WAIT_ASSERTED;
            wait_oe_q <= 1'h0;
        end else begin
            wait_q <= wait_d;
            wait_oe_q <= wait_oe_d;
        end
    end

    // Write strobes, one cycle per sampled write cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strobe_q <= '0;
        end else begin
            strobe_q <= strobe_d;
        end
    end

    // Write data captured from the data pins each cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdata_q <= `DFBS_DATA_RESET;
        end else begin
            wdata_q <= data_in_i;
        end
    end

    // Operation report per die
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            die0_op_q <= dfbs_pkg::DFBS_OP_RESET;
            die1_op_q <= dfbs_pkg::DFBS_OP_RESET;
        end else begin
            die0_op_q <= op_d[0];
            die1_op_q <= op_d[1];
        end
    end

    // Outputs straight from the flip-flops
    assign data_out_o = data_q;
    assign data_oe_o = data_oe_q;
    assign wait_out_o = wait_q;
    assign wait_oe_o = wait_oe_q;
    assign write_strobe_o = strobe_q;
    assign write_data_o = wdata_q;
    assign die0_op_o = die0_op_q;
    assign die1_op_o = die1_op_q;

endmodule : dfbs_bus_select
`default_nettype wire

// *** verif/dfbs_checker.sv ***
// Purpose: Port checks for the bus select block
// Assumes: Outputs follow inputs by one edge
// Notes: Bound at the foot
`timescale 1ns/100ps
`default_nettype none
module dfbs_checker (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Shared controls
    input wire logic mem_reset_n_i,
    input wire logic write_en_n_i,
    input wire logic prog_volt_ok_i,
    // Per-die controls and read state
    input wire logic [1:0] chip_sel_n_i,
    input wire logic [1:0] out_en_n_i,
    input wire logic [1:0] sync_mode_i,
    input wire logic [1:0] byte_read_i,
    input wire logic [15:0] die0_rdata_i,
    // Pin outputs
    input wire logic data_oe_o,
    input wire logic wait_out_o,
    input wire logic wait_oe_o,
    input wire logic [1:0] write_strobe_o,
    input wire logic [15:0] data_out_o
);
    // Die 0 alone selected, reading, writing
    wire s0 = mem_reset_n_i && chip_sel_n_i == 2'h2;
    wire r0 = s0 && !out_en_n_i[0];
    wire w0 = s0 && out_en_n_i[0] && !write_en_n_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_rst_float: assert property (!mem_reset_n_i |=> !data_oe_o && !wait_oe_o) else $error("rst");
    chk_idle_float: assert property (&chip_sel_n_i |=> !data_oe_o && !wait_oe_o) else $error("idle");
    chk_sel_wait: assert property (mem_reset_n_i && !(&chip_sel_n_i) |=> wait_oe_o) else $error("wait");
    chk_oe_wins: assert property (r0 |=> data_oe_o && !write_strobe_o[0]) else $error("oe");
    chk_word_read: assert property (r0 && !byte_read_i[0] |=> data_out_o == $past(die0_rdata_i))
        else $error("word");
    chk_async_wait: assert property (r0 && !sync_mode_i[0] |=> !wait_out_o) else $error("async");
    chk_off_float: assert property (s0 && out_en_n_i[0] |=> !data_oe_o) else $error("off");
    chk_write_volt: assert property (w0 |=> write_strobe_o[0] == $past(prog_volt_ok_i)) else $error("vpp");
    // Main scenarios
    cover property (r0 && byte_read_i[0]);
    cover property (w0 && prog_volt_ok_i);
    cover property (!mem_reset_n_i);
endmodule : dfbs_checker
bind dfbs_bus_select dfbs_checker i_dfbs_checker (.*);
`default_nettype wire

// *** verif/dfbs_host_model.sv ***
// Purpose: Memory controller model for the die controls
// Assumes: Bench picks die and kind each cycle
// Notes: Kind 0 idle, 1 read, 2 write, 3 disable
`timescale 1ns/100ps
`default_nettype none
module dfbs_host_model (
    // Request
    input wire logic die_i,
    input wire logic clash_i,
    input wire logic [1:0] kind_i,
    // Controls
    output logic [1:0] chip_sel_n_o,
    output logic [1:0] out_en_n_o,
    output logic write_en_n_o,
    output logic ram_sel_n_o
);
    // One die at a time; write overlap only when told
    assign chip_sel_n_o = kind_i == 2'h0 ? 2'h3 : 2'h2 >> die_i;
    assign out_en_n_o = kind_i == 2'h1 ? 2'h2 >> die_i : 2'h3;
    assign write_en_n_o = !(kind_i == 2'h2 || clash_i);
    assign ram_sel_n_o = 1'h1;
endmodule : dfbs_host_model
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Random bench for the bus select block
// Assumes: Host model drives the die controls
// Notes: Bench functions give expectations
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic sys_clk_i, rst_n_i, mem_reset_n_i, write_en_n_i, address_valid_strobe_n_i, prog_volt_ok_i, data_oe_o;
    logic wait_out_o, wait_oe_o, die, clash, rg, wg;
    logic [1:0] chip_sel_n_i, out_en_n_i, sync_mode_i, byte_read_i, wait_flow_i, write_strobe_o, kind, ws;
    logic [15:0] die0_rdata_i, die1_rdata_i, data_in_i, data_out_o, write_data_o, rs;
    logic [31:0] r;
    dfbs_pkg::dfbs_op_t die0_op_o, die1_op_o;
    int errors, check_count;
    dfbs_host_model i_dfbs_host_model (.die_i(die), .clash_i(clash), .kind_i(kind), .chip_sel_n_o(chip_sel_n_i),
        .out_en_n_o(out_en_n_i), .write_en_n_o(write_en_n_i), .ram_sel_n_o());
    dfbs_bus_select i_dfbs_bus_select (.*);
    // Clock
    always #50 sys_clk_i = ~sys_clk_i;
    // Xorshift step
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs
    // Expected operation of one die
    function automatic dfbs_pkg::dfbs_op_t eop(input logic cs, input logic oe, input logic sy);
        if (!mem_reset_n_i) return dfbs_pkg::DFBS_OP_RESET;
        if (cs) return dfbs_pkg::DFBS_OP_STANDBY;
        if (!oe) return !address_valid_strobe_n_i && sy ? dfbs_pkg::DFBS_OP_SYNC_ARRAY_READ : dfbs_pkg::DFBS_OP_ASYNC_READ;
        if (write_en_n_i) return dfbs_pkg::DFBS_OP_OUT_DISABLE;
        return prog_volt_ok_i ? dfbs_pkg::DFBS_OP_WRITE : dfbs_pkg::DFBS_OP_WRITE_LOCKED;
    endfunction : eop
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: %h not %h", $time, seen, want);
        end
    endtask : check
    // Counts and verdict
    task automatic give_verdict;
        $display("%0d checks, %0d errors", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // Watchdog at more than twice the run
    initial begin
        #90000;
        errors++;
        give_verdict();
    end
    // Reset, corner table, then random cycles
    initial begin
        {sys_clk_i, rst_n_i, r} = {2'h0, 32'hBDF6C5F0};
        {mem_reset_n_i, address_valid_strobe_n_i, prog_volt_ok_i, die, clash, kind} = '0;
        {sync_mode_i, byte_read_i, wait_flow_i, die0_rdata_i, die1_rdata_i, data_in_i} = '0;
        repeat (6) @(posedge sys_clk_i);
        #10 rst_n_i = 1'h1;
        for (int i = 0; i < 400; i++) begin
            // Mid-run reset: data and wait enables, write strobes and die 1 report must drop at once, before any clock edge
            if (i == 200) begin
                rst_n_i = 1'h0;
                #1;
                check(16'({data_oe_o, wait_oe_o, write_strobe_o}), 16'h0000);
                check(16'(die1_op_o), 16'(dfbs_pkg::DFBS_OP_RESET));
                @(posedge sys_clk_i);
                #10 rst_n_i = 1'h1;
            end
            r = xs(r);
            {die0_rdata_i, die1_rdata_i} = r;
            r = xs(r);
            {data_in_i, mem_reset_n_i, address_valid_strobe_n_i, prog_volt_ok_i, die, kind, sync_mode_i,
                byte_read_i, wait_flow_i} = {r[31:16], r[15:12] != 4'h0, r[10:0]};
            if (i < 8) {mem_reset_n_i, die, kind} = {1'h1, i[2:0]};
            clash = kind == 2'h1 && r[11];
            @(posedge sys_clk_i);
            #10;
            rg = mem_reset_n_i && kind == 2'h1;
            rs = die ? die1_rdata_i : die0_rdata_i;
            ws = mem_reset_n_i && kind == 2'h2 && prog_volt_ok_i ? 2'h1 << die : 2'h0;
            wg = rg && !address_valid_strobe_n_i && sync_mode_i[die] && wait_flow_i[die];
            check(16'(die0_op_o), 16'(eop(chip_sel_n_i[0], out_en_n_i[0], sync_mode_i[0])));
            check(16'(die1_op_o), 16'(eop(chip_sel_n_i[1], out_en_n_i[1], sync_mode_i[1])));
            check(16'(data_oe_o), 16'(rg));
            if (rg) check(data_out_o, byte_read_i[die] ? rs & 16'h00FF : rs);
            check(16'(wait_oe_o), 16'(mem_reset_n_i && kind != 2'h0));
            if (mem_reset_n_i && kind != 2'h0) check(16'(wait_out_o), 16'(wg));
            check(16'(write_strobe_o), 16'(ws));
            if (ws != 2'h0) check(write_data_o, data_in_i);
        end
        give_verdict();
    end
endmodule : tb
`default_nettype wire
